// ---- inc/rtccr_pkg.sv ----
// constants of the calendar time, date and control register block
// assumes one 40 MHz clock shared by bus, calendar and wakeup logic
//
// Contract
// - time word: seconds BCD, units 3:0, tens 6:4, bit 7 reserved
// - time word: minutes BCD, units 11:8, tens 14:12, bit 15 reserved
// - time word: hours BCD, units 19:16, tens 21:20, bits 31:23 reserved
// - time bit 22: zero is AM or 24-hour, one is PM
// - time and date accept writes only in initialization mode
// - system reset clears date shadow to zero when shadow reading selected
// - date word: day BCD 3:0 and 5:4, month BCD 11:8 and 12
// - date word: year BCD 19:16 and 23:20, bits 31:24 reserved
// - date bits 15:13 weekday: 000 disabled, 001 Monday to 111 Sunday
// - control bits 7, 6, 4 writable only in initialization mode
// - summer or winter adjustment takes effect at next seconds boundary
// - bits 2:0 pick wakeup clock: divide 16/8/4/2, 1 Hz, 1 Hz plus 2^16
// - control bit 3 picks stamp edge; changes only while stamping disabled
// - control bit 4 enables reference clock detection
// - control bit 5: zero reads shadows refreshed every two clocks, one direct
// - control bit 6: zero 24-hour format, one AM/PM format
// - control bit 7 enables coarse calibration
// - control bits 8 to 11 enable alarm A, alarm B, wakeup, stamping
// - control bits 12 to 15 enable the four interrupts
// - bit 16 reads zero; writing one outside init adds one hour
// - bit 17 reads zero; writing one outside init subtracts hour unless zero
`default_nettype none
package rtccr_pkg;
  localparam logic [7:0] OFS_TIME = 8'h00;
  localparam logic [7:0] OFS_DATE = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [31:0] TIME_RST = 32'h00000000;
  localparam logic [31:0] DATE_RST = 32'h00002101;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] DATE_SYS_RST = 32'h00000000;
  localparam logic [31:0] TIME_WMASK = 32'h007f7f7f;
  localparam logic [31:0] DATE_WMASK = 32'h00ffff3f;
  localparam logic [31:0] CTRL_STORE_MASK = 32'h0000ffff;
  localparam logic [31:0] CTRL_INIT_MASK = 32'h000000d0;
  localparam int TIME_SEC_LSB = 0;
  localparam int TIME_MIN_LSB = 8;
  localparam int TIME_HR_LSB = 16;
  localparam int TIME_PM_BIT = 22;
  localparam int DATE_DAY_LSB = 0;
  localparam int DATE_MON_LSB = 8;
  localparam int DATE_WD_LSB = 13;
  localparam int DATE_YR_LSB = 16;
  localparam int CTRL_WUSEL_LSB = 0;
  localparam int CTRL_TSEDGE = 3;
  localparam int CTRL_REFDET = 4;
  localparam int CTRL_RDDIRECT = 5;
  localparam int CTRL_FMT12 = 6;
  localparam int CTRL_CCAL = 7;
  localparam int CTRL_ALA = 8;
  localparam int CTRL_ALB = 9;
  localparam int CTRL_WUT = 10;
  localparam int CTRL_TIMESTAMP_ENABLE = 11;
  localparam int CTRL_ALAI = 12;
  localparam int CTRL_ALBI = 13;
  localparam int CTRL_WUTI = 14;
  localparam int CTRL_TSI = 15;
  localparam int CTRL_SUMMER = 16;
  localparam int CTRL_WINTER = 17;
endpackage : rtccr_pkg
`default_nettype wire

// ---- verif/rtccr_regs_assertions.sv ----
// checker for the calendar register block
// assumes binding to rtccr_regs, one clock, async low reset
`default_nettype none
module rtccr_regs_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  // modes
  input wire logic init_mode,
  input wire logic wp_open,
  input wire logic sec_tick,
  // observed outputs
  input wire logic stamp_event,
  input wire logic [31:0] time_now,
  input wire logic [31:0] date_now,
  input wire logic coarse_cal_enable,
  input wire logic alarm_a_enable,
  input wire logic timestamp_enable
);
  import rtccr_pkg::*;
  // ****
  // properties
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_time_resv:
  assert property ($past(rd_en) && $past(addr) == OFS_TIME |-> (rd_data & ~TIME_WMASK) == 32'h0)
    else $error("time reserved bits set");
  a_date_resv:
  assert property ($past(rd_en) && $past(addr) == OFS_DATE |-> (rd_data & ~DATE_WMASK) == 32'h0)
    else $error("date reserved bits set");
  a_ctrl_upper:
  assert property ($past(rd_en) && $past(addr) == OFS_CTRL |-> rd_data[31:16] == 16'h0)
    else $error("control upper bits set");
  a_init_bits:
  assert property (wr_en && addr == OFS_CTRL && !init_mode |=> $stable(coarse_cal_enable))
    else $error("calibration enable changed outside init");
  a_alarm_follow:
  assert property (wr_en && wp_open && addr == OFS_CTRL |=> alarm_a_enable == $past(wr_data[8]))
    else $error("alarm enable not written");
  a_time_hold:
  assert property (!sec_tick && !(wr_en && init_mode) |=> $stable(time_now))
    else $error("time moved without tick");
  a_weekday_step:
  assert property (!$past(init_mode) && $changed(date_now[15:13]) |-> date_now[15:13] ==
    ($past(date_now[15:13]) == 3'h7 ? 3'h1 : $past(date_now[15:13]) + 3'h1))
    else $error("weekday step wrong");
  a_stamp_quiet:
  assert property (!timestamp_enable && !$past(timestamp_enable) |-> !stamp_event)
    else $error("stamp while disabled");
endmodule : rtccr_regs_assertions

bind rtccr_regs rtccr_regs_assertions u_chk (.clk_sys(clk_sys), .resetn(resetn),
  .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .init_mode(init_mode), .wp_open(wp_open), .sec_tick(sec_tick),
  .stamp_event(stamp_event), .time_now(time_now), .date_now(date_now),
  .coarse_cal_enable(coarse_cal_enable), .alarm_a_enable(alarm_a_enable),
  .timestamp_enable(timestamp_enable));
`default_nettype wire

// ---- verif/tb_rtccr_regs.sv ----
// self-checking bench for the calendar register block
// assumes rtccr_pkg compiled first, 40 MHz clock
`default_nettype none
module tb_rtccr_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import rtccr_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic sys_reset = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic init_mode = 1'b0;
  logic wp_open = 1'b0;
  logic sec_tick = 1'b0;
  logic ts_pin = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic [31:0] rd_data;
  logic wake_tick, wake_ext_reload, stamp_event;
  logic [31:0] time_now;
  logic [31:0] date_now;
  logic [9:0] en_out;
  int bad_count = 0;
  int checks_done = 0;
  always #12.5 clk_sys = ~clk_sys;
  rtccr_regs DUT (.clk_sys(clk_sys), .resetn(resetn), .sys_reset(sys_reset),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .init_mode(init_mode), .wp_open(wp_open), .sec_tick(sec_tick),
    .timestamp_input_pin(ts_pin), .wake_tick(wake_tick), .wake_ext_reload(wake_ext_reload),
    .stamp_event(stamp_event), .time_now(time_now), .date_now(date_now),
    .refclock_detect_enable(en_out[0]), .coarse_cal_enable(en_out[1]),
    .alarm_a_enable(en_out[2]), .alarm_b_enable(en_out[3]),
    .wakeup_timer_enable(en_out[4]), .timestamp_enable(en_out[5]),
    .alarm_a_irq_enable(en_out[6]), .alarm_b_irq_enable(en_out[7]),
    .wakeup_irq_enable(en_out[8]), .stamp_irq_enable(en_out[9]));
  // ****
  // helpers
  // ****
  task end_sim;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 chk(nm, rd_data, e);
  endtask : rd
  task mode(input logic i, input logic w);
    @(posedge clk_sys);
    init_mode <= i;
    wp_open <= w;
  endtask : mode
  task tick;
    @(posedge clk_sys) sec_tick <= 1'b1;
    @(posedge clk_sys) sec_tick <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : tick
  task stamp(input logic lvl, input int e, input string nm);
    int n;
    n = 0;
    @(posedge clk_sys) ts_pin <= lvl;
    repeat (8) begin
      @(negedge clk_sys);
      if (stamp_event === 1'b1) n++;
    end
    chk(nm, 32'(n), 32'(e));
  endtask : stamp
  // ****
  // scenarios
  // ****
  task t_reset;
    rd(OFS_TIME, TIME_RST, "time reset");
    rd(OFS_DATE, DATE_RST, "date reset");
    rd(OFS_CTRL, CTRL_RST, "ctrl reset");
    rd(8'h0c, 32'h0, "unmapped");
  endtask : t_reset
  task t_sysrst;
    @(posedge clk_sys) sys_reset <= 1'b1;
    rd(OFS_DATE, DATE_SYS_RST, "date sysrst");
    @(posedge clk_sys) sys_reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(OFS_DATE, DATE_RST, "date shadow");
  endtask : t_sysrst
  task t_protect;
    mode(1'b0, 1'b1);
    wr(OFS_TIME, 32'h00123456);
    rd(OFS_TIME, 32'h0, "time locked");
    wr(OFS_CTRL, 32'h000001d0);
    rd(OFS_CTRL, 32'h00000100, "ctrl init bits");
    mode(1'b1, 1'b0);
    wr(OFS_DATE, 32'h00123456);
    rd(OFS_DATE, DATE_RST, "date locked");
    wr(OFS_CTRL, 32'h00000200);
    rd(OFS_CTRL, 32'h00000100, "ctrl locked");
    mode(1'b1, 1'b1);
    wr(OFS_CTRL, 32'h000001d0);
    rd(OFS_CTRL, 32'h000001d0, "ctrl in init");
    chk("enables init", {22'h0, en_out}, 32'h00000007);
    wr(OFS_CTRL, 32'h0);
  endtask : t_protect
  task t_roll;
    wr(OFS_TIME, 32'hffa3d9d9);
    wr(OFS_DATE, 32'hff99f2f1);
    rd(OFS_TIME, 32'h00235959, "time fields");
    rd(OFS_DATE, 32'h0099f231, "date fields");
    mode(1'b0, 1'b1);
    tick;
    rd(OFS_TIME, 32'h0, "time wrap");
    rd(OFS_DATE, 32'h00002101, "date wrap");
    chk("time live", time_now, 32'h0);
    chk("date live", date_now, 32'h00002101);
  endtask : t_roll
  task t_fmt;
    mode(1'b1, 1'b1);
    wr(OFS_CTRL, 32'h00000040);
    wr(OFS_TIME, 32'h00115959);
    mode(1'b0, 1'b1);
    tick;
    rd(OFS_TIME, 32'h00520000, "noon pm");
    mode(1'b1, 1'b1);
    wr(OFS_TIME, 32'h00515959);
    mode(1'b0, 1'b1);
    tick;
    rd(OFS_TIME, 32'h00120000, "midnight am");
    rd(OFS_DATE, 32'h00004102, "day carry");
  endtask : t_fmt
  task t_adjust;
    mode(1'b1, 1'b1);
    wr(OFS_CTRL, 32'h00000020);
    wr(OFS_TIME, 32'h00100000);
    mode(1'b0, 1'b1);
    wr(OFS_CTRL, 32'h00010020);
    rd(OFS_TIME, 32'h00100000, "summer pending");
    rd(OFS_CTRL, 32'h00000020, "summer reads 0");
    tick;
    rd(OFS_TIME, 32'h00110001, "summer done");
    wr(OFS_CTRL, 32'h00020020);
    tick;
    rd(OFS_TIME, 32'h00100002, "winter done");
    mode(1'b1, 1'b1);
    wr(OFS_TIME, 32'h0);
    mode(1'b0, 1'b1);
    wr(OFS_CTRL, 32'h00020020);
    tick;
    rd(OFS_TIME, 32'h00000001, "winter at 0");
  endtask : t_adjust
  task t_wake;
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CTRL, 32'(c));
      repeat (40) begin
        @(negedge clk_sys);
        if (wake_tick === 1'b1) break;
      end
      n = 0;
      repeat (40) begin
        @(negedge clk_sys);
        n++;
        if (wake_tick === 1'b1) break;
      end
      chk("wake period", 32'(n), 32'(16 >> c));
    end
    wr(OFS_CTRL, 32'h00000004);
    @(posedge clk_sys) sec_tick <= 1'b1;
    @(posedge clk_sys) sec_tick <= 1'b0;
    @(negedge clk_sys);
    chk("wake 1hz", {31'h0, wake_tick}, 32'h1);
    chk("no reload", {31'h0, wake_ext_reload}, 32'h0);
    wr(OFS_CTRL, 32'h00000006);
    repeat (3) @(negedge clk_sys);
    chk("ext reload", {31'h0, wake_ext_reload}, 32'h1);
  endtask : t_wake
  task t_stamp;
    wr(OFS_CTRL, 32'h00000800);
    stamp(1'b1, 1, "rise stamp");
    stamp(1'b0, 0, "fall ignored");
    wr(OFS_CTRL, 32'h0000f708);
    rd(OFS_CTRL, 32'h0000f700, "edge held");
    chk("enables irq", {22'h0, en_out}, 32'h000003dc);
    wr(OFS_CTRL, 32'h00000008);
    wr(OFS_CTRL, 32'h00000808);
    stamp(1'b1, 0, "rise ignored");
    stamp(1'b0, 1, "fall stamp");
    chk("enables stamp", {22'h0, en_out}, 32'h00000020);
  endtask : t_stamp
  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset;
    t_sysrst;
    t_protect;
    t_roll;
    t_fmt;
    t_adjust;
    t_wake;
    t_stamp;
    end_sim;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    end_sim;
  end
endmodule : tb_rtccr_regs
`default_nettype wire

// ---- verilog/rtccr_regs.sv ----
// calendar counters, shadows and control register of the clock
// assumes sec_tick, init_mode and wp_open come from logic on clk_sys
`default_nettype none
module rtccr_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sys_reset,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // mode inputs
  input wire logic init_mode,
  input wire logic wp_open,
  input wire logic sec_tick,
  // pin
  input wire logic timestamp_input_pin,
  // derived outputs
  output logic wake_tick,
  output logic wake_ext_reload,
  output logic stamp_event,
  output logic [31:0] time_now,
  output logic [31:0] date_now,
  output logic refclock_detect_enable,
  output logic coarse_cal_enable,
  output logic alarm_a_enable,
  output logic alarm_b_enable,
  output logic wakeup_timer_enable,
  output logic timestamp_enable,
  output logic alarm_a_irq_enable,
  output logic alarm_b_irq_enable,
  output logic wakeup_irq_enable,
  output logic stamp_irq_enable
);
  import rtccr_pkg::*;

  // ***************************************************
  // bcd helpers
  // ***************************************************
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic logic [7:0] bcd_dec(input logic [7:0] v);
    bcd_dec = (v[3:0] == 4'h0) ? {v[7:4] - 4'h1, 4'h9} : {v[7:4], v[3:0] - 4'h1};
  endfunction : bcd_dec

  function automatic logic [7:0] month_last(input logic [7:0] mo, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (mo)
      8'h02: month_last = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
      default: month_last = 8'h31;
    endcase
  endfunction : month_last

  // ***************************************************
  // state
  // ***************************************************
  logic [31:0] cal_time;
  logic [31:0] cal_date;
  logic [31:0] ctrl;
  logic [31:0] shadow_time;
  logic [31:0] shadow_date;
  logic shadow_phase;
  logic summer_pend;
  logic winter_pend;
  logic [3:0] div_cnt;
  logic ts_s1;
  logic ts_s2;
  logic ts_d;
  logic [31:0] next_time;
  logic [31:0] next_date;
  logic [31:0] next_ctrl;
  logic [31:0] next_rd;
  logic next_wake;

  // ***************************************************
  // decode
  // ***************************************************
  wire sel_time = (addr == OFS_TIME);
  wire sel_date = (addr == OFS_DATE);
  wire sel_ctrl = (addr == OFS_CTRL);
  wire cal_wr_ok = wr_en & init_mode & wp_open;
  wire wr_time = cal_wr_ok & sel_time;
  wire wr_date = cal_wr_ok & sel_date;
  wire wr_ctrl = wr_en & wp_open & sel_ctrl;
  wire tick_now = sec_tick & ~init_mode;
  wire fmt12 = ctrl[CTRL_FMT12];
  wire rd_direct = ctrl[CTRL_RDDIRECT];
  wire [2:0] wusel = ctrl[CTRL_WUSEL_LSB +: 3];
  // bits 7, 6, 4 only in init; edge bit frozen while stamping runs
  wire [31:0] ctrl_wmask = (init_mode ? CTRL_STORE_MASK
                            : (CTRL_STORE_MASK & ~CTRL_INIT_MASK))
                           & ~({31'h0, ctrl[CTRL_TIMESTAMP_ENABLE]} << CTRL_TSEDGE);
  wire set_summer = wr_ctrl & ~init_mode & wr_data[CTRL_SUMMER];
  wire set_winter = wr_ctrl & ~init_mode & wr_data[CTRL_WINTER];

  // ***************************************************
  // field views of the counters
  // ***************************************************
  wire [7:0] sec = {1'b0, cal_time[TIME_SEC_LSB +: 7]};
  wire [7:0] min = {1'b0, cal_time[TIME_MIN_LSB +: 7]};
  wire [7:0] hr = {2'b00, cal_time[TIME_HR_LSB +: 6]};
  wire pm = cal_time[TIME_PM_BIT];
  wire [7:0] day = {2'b00, cal_date[DATE_DAY_LSB +: 6]};
  wire [7:0] mon = {3'b000, cal_date[DATE_MON_LSB +: 5]};
  wire [2:0] wd = cal_date[DATE_WD_LSB +: 3];
  wire [7:0] yr = cal_date[DATE_YR_LSB +: 8];

  // hour one up, with pm flip and day wrap
  wire [7:0] hr_up = fmt12 ? ((hr == 8'h12) ? 8'h01 : bcd_inc(hr))
                           : ((hr == 8'h23) ? 8'h00 : bcd_inc(hr));
  wire pm_up = (fmt12 && hr == 8'h11) ? ~pm : pm;
  wire wrap_up = fmt12 ? (hr == 8'h11 && pm) : (hr == 8'h23);
  // hour one down
  wire [7:0] hr_dn = (fmt12 && hr == 8'h01) ? 8'h12 : bcd_dec(hr);
  wire pm_dn = (fmt12 && hr == 8'h12) ? ~pm : pm;

  // ***************************************************
  // calendar next state
  // ***************************************************
  always_comb begin
    logic [7:0] s;
    logic [7:0] m;
    logic [7:0] h;
    logic p;
    logic [7:0] d;
    logic [7:0] mo;
    logic [2:0] w;
    logic [7:0] y;
    logic hour_carry;
    logic day_carry;
    s = sec;
    m = min;
    h = hr;
    p = pm;
    d = day;
    mo = mon;
    w = wd;
    y = yr;
    hour_carry = 1'b0;
    day_carry = 1'b0;
    if (tick_now) begin
      if (s == 8'h59) begin
        s = 8'h00;
        if (m == 8'h59) begin
          m = 8'h00;
          hour_carry = 1'b1;
        end else begin
          m = bcd_inc(m);
        end
      end else begin
        s = bcd_inc(s);
      end
      // pending adjustment lands on this boundary, masking a carry
      if (summer_pend) begin
        h = hr_up;
        p = pm_up;
      end else if (winter_pend && hr != 8'h00) begin
        h = hr_dn;
        p = pm_dn;
      end else if (hour_carry) begin
        h = hr_up;
        p = pm_up;
        day_carry = wrap_up;
      end
      if (day_carry) begin
        if (w != 3'h0) begin
          w = (w == 3'h7) ? 3'h1 : w + 3'h1;
        end
        if (d == month_last(mon, yr)) begin
          d = 8'h01;
          if (mo == 8'h12) begin
            mo = 8'h01;
            y = (y == 8'h99) ? 8'h00 : bcd_inc(y);
          end else begin
            mo = bcd_inc(mo);
          end
        end else begin
          d = bcd_inc(d);
        end
      end
    end
    next_time = 32'h0;
    next_time[TIME_SEC_LSB +: 7] = s[6:0];
    next_time[TIME_MIN_LSB +: 7] = m[6:0];
    next_time[TIME_HR_LSB +: 6] = h[5:0];
    next_time[TIME_PM_BIT] = p;
    next_date = 32'h0;
    next_date[DATE_DAY_LSB +: 6] = d[5:0];
    next_date[DATE_MON_LSB +: 5] = mo[4:0];
    next_date[DATE_WD_LSB +: 3] = w;
    next_date[DATE_YR_LSB +: 8] = y;
    if (wr_time) begin
      next_time = wr_data & TIME_WMASK;
    end
    if (wr_date) begin
      next_date = wr_data & DATE_WMASK;
    end
  end

  // ***************************************************
  // control, read mux, wakeup tick
  // ***************************************************
  assign next_ctrl = wr_ctrl ? ((ctrl & ~ctrl_wmask) | (wr_data & ctrl_wmask)) : ctrl;

  // adjust bits are not stored, so they read zero
  assign next_rd = ~rd_en ? 32'h0 :
                   sel_time ? (rd_direct ? cal_time : shadow_time) :
                   sel_date ? (rd_direct ? cal_date : shadow_date) :
                   sel_ctrl ? (ctrl & CTRL_STORE_MASK) : 32'h0;

  always_comb begin
    case (wusel)
      3'h0: next_wake = (div_cnt == 4'hf);
      3'h1: next_wake = (div_cnt[2:0] == 3'h7);
      3'h2: next_wake = (div_cnt[1:0] == 2'h3);
      3'h3: next_wake = div_cnt[0];
      default: next_wake = sec_tick;
    endcase
  end

  wire ts_rise = ts_s2 & ~ts_d;
  wire ts_fall = ~ts_s2 & ts_d;
  wire next_stamp = ctrl[CTRL_TIMESTAMP_ENABLE]
                    & (ctrl[CTRL_TSEDGE] ? ts_fall : ts_rise);

  // ***************************************************
  // registers
  // ***************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cal_time <= TIME_RST;
      cal_date <= DATE_RST;
      ctrl <= CTRL_RST;
      rd_data <= 32'h0;
    end else begin
      cal_time <= next_time;
      cal_date <= next_date;
      ctrl <= next_ctrl;
      rd_data <= next_rd;
    end
  end

  // set wins over the boundary that clears
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      summer_pend <= 1'b0;
      winter_pend <= 1'b0;
    end else begin
      summer_pend <= (summer_pend & ~tick_now) | set_summer;
      winter_pend <= (winter_pend & ~tick_now) | set_winter;
    end
  end

  // shadows follow the counters every second clock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shadow_time <= TIME_RST;
      shadow_date <= DATE_SYS_RST;
      shadow_phase <= 1'b0;
    end else if (sys_reset) begin
      shadow_date <= DATE_SYS_RST;
      shadow_phase <= 1'b0;
    end else begin
      shadow_phase <= ~shadow_phase;
      if (shadow_phase) begin
        shadow_time <= cal_time;
        shadow_date <= cal_date;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 4'h0;
      wake_tick <= 1'b0;
      wake_ext_reload <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
      wake_tick <= next_wake;
      wake_ext_reload <= wusel[2] & wusel[1];
    end
  end

  // pin synchroniser, edge taken after the second stage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ts_s1 <= 1'b0;
      ts_s2 <= 1'b0;
      ts_d <= 1'b0;
      stamp_event <= 1'b0;
    end else begin
      ts_s1 <= timestamp_input_pin;
      ts_s2 <= ts_s1;
      ts_d <= ts_s2;
      stamp_event <= next_stamp;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  assign time_now = cal_time;
  assign date_now = cal_date;
  assign refclock_detect_enable = ctrl[CTRL_REFDET];
  assign coarse_cal_enable = ctrl[CTRL_CCAL];
  assign alarm_a_enable = ctrl[CTRL_ALA];
  assign alarm_b_enable = ctrl[CTRL_ALB];
  assign wakeup_timer_enable = ctrl[CTRL_WUT];
  assign timestamp_enable = ctrl[CTRL_TIMESTAMP_ENABLE];
  assign alarm_a_irq_enable = ctrl[CTRL_ALAI];
  assign alarm_b_irq_enable = ctrl[CTRL_ALBI];
  assign wakeup_irq_enable = ctrl[CTRL_WUTI];
  assign stamp_irq_enable = ctrl[CTRL_TSI];

endmodule : rtccr_regs
`default_nettype wire
